//--- bench/windowed_watchdog_timer_tb.sv
// self-checking bench for the windowed watchdog
`timescale 1ns/1ps
module windowed_watchdog_timer_tb import wwd_pkg::*;;
	logic ref_clk = 0, nrst = 0, debug_mode = 0, wr_en = 0, rd_en = 0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, rel, v1, v2;
	logic timeout_nmi_flag, system_reset_request, irq;
	wire [7:0] rdata;
	int fails = 0, comparisons = 0, n, e;
	wwd_top u_wwd_top (.ref_clk(ref_clk), .nrst(nrst), .debug_mode(debug_mode), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .timeout_nmi_flag(timeout_nmi_flag),
		.system_reset_request(system_reset_request), .irq(irq));
	initial forever #10 ref_clk = ~ref_clk;
	// model: clocks from service to overflow
	function int period(input int s, input int r);
		return (2 ** (1 + 6 * s)) * (65536 - r * 256);
	endfunction : period
	task check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	// bus cycles leave one idle slot so a strobe never gets two updates at one edge
	task wr(input logic [3:0] a, input logic [7:0] d);
		wr_en <= 1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr_en <= 0;
		@(posedge ref_clk);
	endtask : wr
	task rd(input logic [3:0] a, output logic [7:0] d);
		rd_en <= 1;
		addr <= a;
		@(posedge ref_clk);
		rd_en <= 0;
		#1 d = rdata;
		@(posedge ref_clk);
	endtask : rd
	task rc(input logic [3:0] a, input logic [7:0] exp);
		rd(a, v1);
		check(v1, exp);
	endtask : rc
	task rst;
		nrst <= 0;
		repeat (5) @(posedge ref_clk);
		nrst <= 1;
		@(posedge ref_clk);
	endtask : rst
	task wait_for(input bit rq);
		n = 0;
		while ((rq ? system_reset_request : timeout_nmi_flag) !== 1'b1 && n < 40000) begin
			@(posedge ref_clk);
			n++;
		end
	endtask : wait_for
	task print_verdict;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict
	// hang guard sized above the longest overflow plus prewarning
	initial begin
		repeat (80000) @(posedge ref_clk);
		fails++;
		print_verdict();
	end
	initial begin
		void'($urandom(46630));
		rst();
		rc(WWD_RELOAD_ADDR, WWD_RELOAD_RST);
		rc(WWD_WINDOW_ADDR, WWD_WINDOW_RST);
		rc(WWD_CTRL_ADDR, 8'(WWD_CTRL_RST));
		rc(WWD_MASK_ADDR, 8'(WWD_MASK_RST));
		rc(4'h9, 8'h00);
		rel = 8'($urandom);
		wr(WWD_RELOAD_ADDR, rel);
		wr(WWD_SERVICE_ADDR, 8'h00);
		rc(WWD_CNT_HI_ADDR, rel);
		rc(WWD_STATUS_ADDR, 8'h00);
		debug_mode <= 1;
		repeat (4) @(posedge ref_clk);
		rd(WWD_CNT_LO_ADDR, v2);
		repeat (20) @(posedge ref_clk);
		rc(WWD_CNT_LO_ADDR, v2);
		debug_mode <= 0;
		// early service with the window armed
		rst();
		wr(WWD_MASK_ADDR, 8'h02);
		wr(WWD_CTRL_ADDR, 8'h02);
		wr(WWD_WINDOW_ADDR, 8'hFF);
		wr(WWD_SERVICE_ADDR, 8'h00);
		rc(WWD_STATUS_ADDR, 8'h06);
		check(timeout_nmi_flag, 1'b0);
		check(irq, 1'b1);
		wr(WWD_MASK_ADDR, 8'h00);
		// irq drops at the edge that ends the write; look once it has settled
		#1 check(irq, 1'b0);
		@(posedge ref_clk);
		wait_for(1);
		check(16'(n <= 96), 16'h0001);
		// overflow period and prewarning length at both rates
		for (int s = 0; s < 2; s++) begin
			rst();
			wr(WWD_CTRL_ADDR, 8'(s));
			wr(WWD_RELOAD_ADDR, 8'hFF);
			wr(WWD_SERVICE_ADDR, 8'h00);
			wait_for(0);
			e = period(s, 255);
			check(16'(n >= e - 8 && n <= e + 8), 16'h0001);
			wait_for(1);
			e = 48 * (2 ** (1 + 6 * s));
			check(16'(n >= e - 8 && n <= e + 8), 16'h0001);
			wr(WWD_MASK_ADDR, 8'h01);
			rc(WWD_STATUS_ADDR, 8'h05);
			check(irq, 1'b1);
			wr(WWD_STATUS_ADDR, 8'h01);
			rc(WWD_STATUS_ADDR, 8'h04);
			check({irq, timeout_nmi_flag}, 2'b00);
		end
		print_verdict();
	end
endmodule : windowed_watchdog_timer_tb

//--- bench/wwd_top_properties.sv
// port-level properties of the watchdog top
`timescale 1ns/1ps
module wwd_chk (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic debug_mode,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] rdata,
	input wire logic timeout_nmi_flag,
	input wire logic system_reset_request,
	input wire logic irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// write-one clear of the overflow status bit
	wire clr0 = wr_en && addr == 4'h6 && wdata[0];
	sequence s_mask_off; wr_en && addr == 4'h7 && wdata == 8'h00; endsequence
	property p_rd_idle; !$past(rd_en) |-> rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	property p_unmapped; rd_en && addr[3] |=> rdata == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_ctrl_rd; rd_en && addr == 4'h0 |=> rdata[7:2] == 6'h00; endproperty
	a_ctrl_rd: assert property (p_ctrl_rd) else $error("control spare bits set");
	property p_rst_hold; system_reset_request |=> system_reset_request; endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("reset request dropped");
	property p_nmi_hold; timeout_nmi_flag && !clr0 && !$past(clr0) |=> timeout_nmi_flag; endproperty
	a_nmi_hold: assert property (p_nmi_hold) else $error("timeout flag dropped");
	property p_prewarn; $rose(timeout_nmi_flag) && !system_reset_request |-> !system_reset_request [*8]; endproperty
	a_prewarn: assert property (p_prewarn) else $error("reset without prewarning");
	property p_debug; debug_mode && $past(debug_mode) && $past(debug_mode, 2) && $past(debug_mode, 3)
		|-> !$rose(timeout_nmi_flag) && !$rose(system_reset_request); endproperty
	a_debug: assert property (p_debug) else $error("event while frozen");
	property p_mask_off; s_mask_off |-> ##2 !irq; endproperty
	a_mask_off: assert property (p_mask_off) else $error("irq with mask clear");
endmodule : wwd_chk
bind wwd_top wwd_chk u_wwd_chk (.ref_clk(ref_clk), .nrst(nrst), .debug_mode(debug_mode), .addr(addr),
	.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .timeout_nmi_flag(timeout_nmi_flag),
	.system_reset_request(system_reset_request), .irq(irq));

//--- design/wwd_counter.sv
// 16-bit two-stage counter with service reload and window check
`timescale 1ns/1ps
module wwd_counter import wwd_pkg::*; (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic tick,
	input wire logic run,
	input wire logic service,
	input wire wwd_cfg_t cfg,
	output logic [15:0] count,
	output wwd_evt_t evt
);
	logic [7:0] low_stage;
	logic [7:0] high_stage;
	wire low_wrap = tick && run && (low_stage == 8'hFF);
	wire high_wrap = low_wrap && (high_stage == 8'hFF);
	// window is 0000 up to boundary:00 inclusive
	wire in_window = ({high_stage, low_stage} <= {cfg.window, 8'h00}); // R8
	wire bad = service && cfg.win_en && in_window; // R7 R9 R12
	assign count = {high_stage, low_stage};
	assign evt = '{overflow: high_wrap && !service, svc_ok: service && !bad, svc_bad: bad};
	// service wins over a same-cycle tick
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			low_stage <= 8'h00;
			high_stage <= 8'h00;
		end else if (service) begin
			low_stage <= 8'h00; // R2 R3
			high_stage <= cfg.reload; // R2 R3
		end else if (tick && run) begin
			low_stage <= low_stage + 8'h01; // R1 R2
			if (low_wrap) begin
				high_stage <= high_stage + 8'h01; // R2
			end
		end
	end
endmodule : wwd_counter

//--- design/wwd_pkg.sv
// shared constants and types for the windowed watchdog
package wwd_pkg;
	// register offsets
	localparam logic [3:0] WWD_CTRL_ADDR = 4'h0;
	localparam logic [3:0] WWD_RELOAD_ADDR = 4'h1;
	localparam logic [3:0] WWD_WINDOW_ADDR = 4'h2;
	localparam logic [3:0] WWD_SERVICE_ADDR = 4'h3;
	localparam logic [3:0] WWD_CNT_LO_ADDR = 4'h4;
	localparam logic [3:0] WWD_CNT_HI_ADDR = 4'h5;
	localparam logic [3:0] WWD_STATUS_ADDR = 4'h6;
	localparam logic [3:0] WWD_MASK_ADDR = 4'h7;
	// control field positions
	localparam int WWD_CTRL_RATE_BIT = 0;
	localparam int WWD_CTRL_WIN_BIT = 1;
	// status field positions
	localparam int WWD_ST_TIMEOUT_BIT = 0;
	localparam int WWD_ST_WINVIOL_BIT = 1;
	localparam int WWD_ST_PREWARN_BIT = 2;
	// reset values
	localparam logic [7:0] WWD_RELOAD_RST = 8'h00;
	localparam logic [7:0] WWD_WINDOW_RST = 8'h00;
	localparam logic [1:0] WWD_CTRL_RST = 2'h0;
	localparam logic [2:0] WWD_MASK_RST = 3'h0;
	// timing counts: tick dividers and prewarning length
	localparam logic [6:0] WWD_DIV_SLOW = 7'h7F;
	localparam logic [6:0] WWD_DIV_FAST = 7'h01;
	localparam logic [7:0] WWD_PREWARN_TICKS = 8'h30;
	// software-written settings
	typedef struct packed {
		logic win_en;
		logic rate_sel;
		logic [7:0] reload;
		logic [7:0] window;
	} wwd_cfg_t;
	// counter state handed to the event logic
	typedef struct packed {
		logic overflow;
		logic svc_ok;
		logic svc_bad;
	} wwd_evt_t;
	typedef enum logic [1:0] {WWD_RUN, WWD_PREWARN, WWD_RESET} wwd_state_t;
endpackage : wwd_pkg

//--- design/wwd_top.sv
// windowed watchdog top: register port, prescaler, prewarning, interrupt
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
// Contract
// (R1) 16-bit up-counter advances per prescaled tick, pclk/2 or pclk/128 by one select bit.
// (R2) Counter is two 8-bit stages; service clears low, loads high from reload.
// (R3) After service counting resumes from reload times 256.
// (R4) Debug mode freezes the counter; no service needed.
// (R5) Overflow without service raises timeout flag and enters prewarning.
// (R6) Prewarning counts 30 hex ticks, then requests system reset.
// (R7) Service inside forbidden window enters prewarning without timeout flag.
// (R8) Forbidden window spans zero to boundary byte with zero low byte.
// (R9) Window check only when window feature enabled.
// (R10) Period is 2^(1+6*sel) times (65536 - reload*256) clocks.
// (R11) Software keeps boundary >= reload and services outside window before overflow.
// (R12) Service is a one-cycle strobe judged against the current count.
module wwd_top import wwd_pkg::*; (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic debug_mode,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	output logic timeout_nmi_flag,
	output logic system_reset_request,
	output logic irq
);
	logic dbg_s1;
	logic dbg_s2;
	logic [6:0] div_cnt;
	logic tick;
	logic [7:0] reload_high_byte;
	logic [7:0] window_boundary_byte;
	logic tick_rate_select;
	logic win_en;
	logic [2:0] status;
	logic [2:0] mask;
	logic [7:0] pw_cnt;
	wwd_state_t state;
	wwd_state_t next_state;
	logic [15:0] watchdog_counter;
	wwd_evt_t evt;
	wwd_cfg_t cfg;

	// debug is a pin from another domain
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dbg_s1 <= 1'b0;
			dbg_s2 <= 1'b0;
		end else begin
			dbg_s1 <= debug_mode;
			dbg_s2 <= dbg_s1;
		end
	end

	// register decode
	wire wr_ctrl = wr_en && (addr == WWD_CTRL_ADDR);
	wire wr_reload = wr_en && (addr == WWD_RELOAD_ADDR);
	wire wr_window = wr_en && (addr == WWD_WINDOW_ADDR);
	wire wr_status = wr_en && (addr == WWD_STATUS_ADDR);
	wire wr_mask = wr_en && (addr == WWD_MASK_ADDR);
	// a write of any data to the service address in the run state is the service strobe
	wire service = wr_en && (addr == WWD_SERVICE_ADDR) && (state == WWD_RUN); // R12
	wire counting = !dbg_s2; // R4
	assign cfg = '{win_en: win_en, rate_sel: tick_rate_select, reload: reload_high_byte,
		window: window_boundary_byte};

	// prescaler: one-cycle tick every 2 or 128 clocks, cleared in debug
	wire [6:0] div_top = tick_rate_select ? WWD_DIV_SLOW : WWD_DIV_FAST; // R1 R10
	wire div_done = (div_cnt >= div_top);
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			div_cnt <= 7'h00;
			tick <= 1'b0;
		end else if (!counting || service) begin
			// restart the prescaler so a service starts a full period
			div_cnt <= 7'h00;
			tick <= 1'b0;
		end else begin
			div_cnt <= div_done ? 7'h00 : div_cnt + 7'h01;
			tick <= div_done; // R1 R10
		end
	end

	wwd_counter u_counter (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.tick(tick),
		.run(counting && (state == WWD_RUN)),
		.service(service),
		.cfg(cfg),
		.count(watchdog_counter),
		.evt(evt)
	);

	// watchdog sequencing
	wire pw_done = tick && counting && (pw_cnt == WWD_PREWARN_TICKS - 8'h01);
	always_comb begin
		next_state = state;
		unique case (state)
			WWD_RUN: if (evt.overflow || evt.svc_bad) next_state = WWD_PREWARN; // R5 R7
			WWD_PREWARN: if (pw_done) next_state = WWD_RESET; // R6
			WWD_RESET: next_state = WWD_RESET;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state <= WWD_RUN;
			pw_cnt <= 8'h00;
		end else begin
			state <= next_state;
			if (state == WWD_PREWARN && tick && counting) begin
				pw_cnt <= pw_cnt + 8'h01; // R6
			end
		end
	end

	// configuration registers; window enable steers the check
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			reload_high_byte <= WWD_RELOAD_RST;
			window_boundary_byte <= WWD_WINDOW_RST;
			{win_en, tick_rate_select} <= WWD_CTRL_RST;
			mask <= WWD_MASK_RST;
		end else begin
			if (wr_reload) reload_high_byte <= wdata;
			if (wr_window) window_boundary_byte <= wdata;
			if (wr_ctrl) begin
				tick_rate_select <= wdata[WWD_CTRL_RATE_BIT]; // R1
				win_en <= wdata[WWD_CTRL_WIN_BIT]; // R9
			end
			if (wr_mask) mask <= wdata[2:0];
		end
	end

	// sticky status, write one to clear; a new event beats the clear
	wire [2:0] evt_set = {evt.svc_bad || evt.overflow, evt.svc_bad, evt.overflow};
	wire [2:0] clr = wr_status ? wdata[2:0] : 3'h0;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			status <= 3'h0;
		end else begin
			status <= (status & ~clr) | evt_set; // R5 R7
		end
	end

	// outputs, all registered
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			timeout_nmi_flag <= 1'b0;
			system_reset_request <= 1'b0;
			irq <= 1'b0;
		end else begin
			// timeout flag follows its sticky bit, never set by a window fault
			timeout_nmi_flag <= status[WWD_ST_TIMEOUT_BIT] && !clr[WWD_ST_TIMEOUT_BIT] || evt.overflow; // R5
			system_reset_request <= (next_state == WWD_RESET); // R6 R7
			irq <= |(((status & ~clr) | evt_set) & mask);
		end
	end

	// read data one cycle after the strobe
	wire [7:0] rd_mux =
		(addr == WWD_CTRL_ADDR) ? {6'h00, win_en, tick_rate_select} :
		(addr == WWD_RELOAD_ADDR) ? reload_high_byte :
		(addr == WWD_WINDOW_ADDR) ? window_boundary_byte :
		(addr == WWD_CNT_LO_ADDR) ? watchdog_counter[7:0] :
		(addr == WWD_CNT_HI_ADDR) ? watchdog_counter[15:8] :
		(addr == WWD_STATUS_ADDR) ? {5'h00, status} :
		(addr == WWD_MASK_ADDR) ? {5'h00, mask} : 8'h00;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) rdata <= 8'h00;
		else rdata <= rd_en ? rd_mux : 8'h00;
	end
endmodule : wwd_top
